/* File: pkg/jtp_consts.svh */
// Purpose: shared constants of the scan port link and its two ends
// Assumes: included by the package and both end modules
// Notes: counts are in ref_clk cycles at 40 MHz
// Summary of operation
// - sample test inputs on rising test clock
// - change outputs only on falling test clock
// - controller changes mode select on falling edge
// - capture-IR loads pattern 10000001 into IR
// - shift-IR moves one bit per rising edge
// - all-ones instruction selects bypass after update
// - exit edge from shift still shifts
// - first falling edge in shift enables output
// - exit1 falling edge floats output; idle elsewhere
// - update-IR falling edge latches new instruction
// - bypass captures zero leaving capture-DR
// - bypass delays data by one stage
// - update-DR falling edge loads parallel output
// - controller drops mode select to leave reset
// - controller raises mode select on last shift
// - three high edges after update return to reset
`ifndef JTP_CONSTS_SVH
`define JTP_CONSTS_SVH
`define JTP_IR_W 8
`define JTP_IR_CAPTURE 8'h81
`define JTP_IR_BYPASS 8'hff
`define JTP_DR_W 8
`define JTP_REF_NS 25
`define JTP_TCK_NS 200
`define JTP_TCK_HALF (`JTP_TCK_NS / (2 * `JTP_REF_NS))
`define JTP_RESET_STEPS 5
`define JTP_BUF_DEPTH 2
`endif

/* File: pkg/jtp_pkg.sv */
// Purpose: types shared by both ends of the scan port link
// Assumes: jtp_consts.svh holds the numbers
// Notes: controller states are one-hot
package jtp_pkg;
`include "jtp_consts.svh"
    // sixteen controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PAUDR = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDDR = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PAUIR = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPDIR = 16'h8000
    } jtp_state_e;
    // instruction word
    typedef logic [`JTP_IR_W-1:0] jtp_ir_t;
endpackage

/* File: pkg/jtp_link_if.sv */
// Purpose: four-wire scan link joining controller end and device end
// Assumes: data output is a tri-state pin, resolved here from its enable
// Notes: an undriven data output reads high, as with a pull-up
`timescale 1ns/1ps
interface jtp_link_if;
    logic tck; // test clock, made by the controller end
    logic tms; // mode select
    logic tdi; // serial data toward device
    logic tdo; // device serial data value
    logic tdo_oe; // device drives tdo while high
    logic tdo_line; // resolved wire level
    // resolve the tri-state pin
    assign tdo_line = tdo_oe ? tdo : 1'b1;
    modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe);
    modport host (output tck, output tms, output tdi, input tdo_line);
endinterface

/* File: design/jtp_dev.sv */
// Purpose: device end of the scan port: controller, instruction and data paths
// Assumes: test clock is far slower than ref_clk and is found by sampling
// Notes: link inputs pass two flip-flops before use
//        edges act about three ref_clk cycles after the pin moves
`timescale 1ns/1ps
`include "jtp_consts.svh"
module jtp_dev
    import jtp_pkg::*;
#(
    parameter int DR_W = `JTP_DR_W
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // scan link
    jtp_link_if.dev link,
    // normal-function side
    input wire logic [DR_W-1:0] nf_in,
    output logic [DR_W-1:0] nf_out,
    // status
    output jtp_ir_t ir_active,
    output jtp_state_e tap_state
);
    logic [2:0] tck_sy; // tck synchroniser plus edge history
    logic [1:0] tms_sy; // tms synchroniser
    logic [1:0] tdi_sy; // tdi synchroniser
    logic tck_rise; // rising test clock seen
    logic tck_fall; // falling test clock seen
    jtp_state_e next_state; // controller next state
    jtp_ir_t ir_sh; // instruction shift stage
    logic bypass_bit; // one-bit bypass stage
    logic [DR_W-1:0] dr_sh; // data shift stage
    logic [DR_W-1:0] nf_smp; // normal inputs caught on rising edge
    logic byp_sel; // bypass instruction active
    logic tdo_q; // data output flop
    logic tdo_en; // data output enable flop

    // link synchronisers; first stage read only by second
    always_ff @(posedge ref_clk)
    begin
        // reset levels match the idle link, so no false edge follows
        if (!nrst)
        begin
            tck_sy <= 3'h0;
            tms_sy <= 2'h3;
            tdi_sy <= 2'h0;
        end
        else
        begin
            // one stage per ref_clk cycle
            tck_sy <= {tck_sy[1:0], link.tck};
            tms_sy <= {tms_sy[0], link.tms};
            tdi_sy <= {tdi_sy[0], link.tdi};
        end
    end

    // edges from second and third stages
    // a tck level lasting under one ref_clk cycle can be missed
    assign tck_rise = tck_sy[1] & ~tck_sy[2];
    assign tck_fall = ~tck_sy[1] & tck_sy[2];
    assign byp_sel = (ir_active == `JTP_IR_BYPASS);

    // controller next state from mode select
    always_comb
    begin
        // hold unless the mode select level says otherwise
        next_state = tap_state;
        unique case (tap_state)
            ST_TLR: next_state = tms_sy[1] ? ST_TLR : ST_RTI;
            ST_RTI: next_state = tms_sy[1] ? ST_SELDR : ST_RTI;
            ST_SELDR: next_state = tms_sy[1] ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: next_state = tms_sy[1] ? ST_EX1DR : ST_SHDR;
            ST_SHDR: next_state = tms_sy[1] ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: next_state = tms_sy[1] ? ST_UPDDR : ST_PAUDR;
            ST_PAUDR: next_state = tms_sy[1] ? ST_EX2DR : ST_PAUDR;
            ST_EX2DR: next_state = tms_sy[1] ? ST_UPDDR : ST_SHDR;
            ST_UPDDR: next_state = tms_sy[1] ? ST_SELDR : ST_RTI;
            ST_SELIR: next_state = tms_sy[1] ? ST_TLR : ST_CAPIR;
            ST_CAPIR: next_state = tms_sy[1] ? ST_EX1IR : ST_SHIR;
            ST_SHIR: next_state = tms_sy[1] ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: next_state = tms_sy[1] ? ST_UPDIR : ST_PAUIR;
            ST_PAUIR: next_state = tms_sy[1] ? ST_EX2IR : ST_PAUIR;
            ST_EX2IR: next_state = tms_sy[1] ? ST_UPDIR : ST_SHIR;
            ST_UPDIR: next_state = tms_sy[1] ? ST_SELDR : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    end

    // controller advances only on rising test clock
    // the decision uses mode select as it stood at that rise
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            tap_state <= ST_TLR;
        else if (tck_rise)
            tap_state <= next_state;
    end

    // instruction shift stage, acts on the state being left
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            ir_sh <= `JTP_IR_CAPTURE;
        else if (tck_rise)
        begin
            // leaving capture loads the fixed pattern, shift takes tdi
            if (tap_state == ST_CAPIR)
                ir_sh <= `JTP_IR_CAPTURE;
            else if (tap_state == ST_SHIR)
                ir_sh <= {tdi_sy[1], ir_sh[`JTP_IR_W-1:1]};
        end
    end

    // active instruction; reset state selects bypass
    // changes only on a fall, so the data path never sees half an update
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            ir_active <= `JTP_IR_BYPASS;
        else if (tck_fall && tap_state == ST_TLR)
            ir_active <= `JTP_IR_BYPASS;
        else if (tck_fall && tap_state == ST_UPDIR)
            ir_active <= ir_sh;
    end

    // normal inputs sampled on rising edge
    // the data register captures the value from the previous rise
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            nf_smp <= '0;
        else if (tck_rise)
            nf_smp <= nf_in;
    end

    // bypass stage
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            bypass_bit <= 1'b0;
        else if (tck_rise && byp_sel)
        begin
            // capture clears the stage, shift takes the next tdi bit
            if (tap_state == ST_CAPDR)
                bypass_bit <= 1'b0;
            else if (tap_state == ST_SHDR)
                bypass_bit <= tdi_sy[1];
        end
    end

    // data shift stage for any other instruction
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            dr_sh <= '0;
        else if (tck_rise && !byp_sel)
        begin
            // capture takes the sampled normal inputs
            if (tap_state == ST_CAPDR)
                dr_sh <= nf_smp;
            else if (tap_state == ST_SHDR)
                dr_sh <= {tdi_sy[1], dr_sh[DR_W-1:1]};
        end
    end

    // parallel output, changed only on falling edge
    // bypass leaves the output as it was
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            nf_out <= '0;
        else if (tck_fall && tap_state == ST_UPDDR && !byp_sel)
            nf_out <= dr_sh;
    end

    // serial output and its enable, on falling edge only
    // every fall re-decides the drive from the current state
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            tdo_q <= 1'b0;
            tdo_en <= 1'b0;
        end
        else if (tck_fall)
        begin
            unique case (tap_state)
                ST_SHIR:
                begin
                    tdo_q <= ir_sh[0];
                    tdo_en <= 1'b1;
                end
                ST_SHDR:
                begin
                    tdo_q <= byp_sel ? bypass_bit : dr_sh[0];
                    tdo_en <= 1'b1;
                end
                // exit, pause, update and idle states float the pin
                default:
                    tdo_en <= 1'b0;
            endcase
        end
    end

    // pin drive from flops
    // the interface turns a low enable into the idle high level
    assign link.tdo = tdo_q;
    assign link.tdo_oe = tdo_en;
endmodule

/* File: design/jtp_host.sv */
// Purpose: controller end: runs one IR scan and one DR scan per request
// Assumes: scan path is walked from reset and returned to reset each time
// Notes: results queue in a small buffer; a full buffer holds off requests
`timescale 1ns/1ps
`include "jtp_consts.svh"
module jtp_host
    import jtp_pkg::*;
#(
    parameter int DR_W = `JTP_DR_W,
    parameter int TCK_HALF = `JTP_TCK_HALF,
    parameter int DEPTH = `JTP_BUF_DEPTH
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // scan link
    jtp_link_if.host link,
    // request side
    input wire logic req_valid,
    output logic req_ready,
    input wire jtp_ir_t req_ir,
    input wire logic [DR_W-1:0] req_dr,
    // result side
    output logic rsp_valid,
    input wire logic rsp_ready,
    output jtp_ir_t rsp_ir,
    output logic [DR_W-1:0] rsp_dr
);
    localparam int P = `JTP_RESET_STEPS; // leading high steps
    localparam int LAST = P + 20 + DR_W; // final step index
    localparam int CW = $clog2(DEPTH + 1); // count width
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1; // pointer width
    logic [1:0] tdo_sy; // tdo synchroniser
    logic busy; // scan in progress
    logic [7:0] step; // current test clock step
    logic [7:0] div; // half period counter
    logic tck_q, tms_q, tdi_q; // link output flops
    jtp_ir_t ir_tx, ir_cap; // instruction out and captured
    logic [DR_W-1:0] dr_tx, dr_cap; // data out and captured
    logic [`JTP_IR_W+DR_W-1:0] mem [DEPTH]; // result buffer
    logic [AW-1:0] wr_ptr, rd_ptr; // buffer pointers
    logic [CW-1:0] count; // buffer fill
    logic push, pop, accept, half, last_fall; // events
    logic [CW-1:0] next_count; // fill after this cycle

    // mode select level for a given step
    function automatic logic step_tms(input int k);
        int j;
        j = k - P;
        if (k < P) return 1'b1;
        if (j == 0) return 1'b0;
        if (j <= 2) return 1'b1;
        if (j <= 4) return 1'b0;
        if (j < 13) return (j == 12);
        if (j <= 14) return 1'b1;
        if (j <= 16) return 1'b0;
        if (j < 17 + DR_W) return (j == 16 + DR_W);
        return 1'b1;
    endfunction

    // shift step tests on a step index
    function automatic logic is_ir(input int k);
        return (k >= P + 5) && (k < P + 13);
    endfunction
    function automatic logic is_dr(input int k);
        return (k >= P + 17) && (k < P + 17 + DR_W);
    endfunction

    assign half = busy && (div == 8'(TCK_HALF - 1));
    assign last_fall = half && tck_q && (step == 8'(LAST));
    assign accept = req_valid && req_ready;
    assign push = last_fall;
    assign pop = rsp_valid && rsp_ready;
    assign next_count = count + CW'(push) - CW'(pop);

    // tdo synchroniser; first stage read only by second
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
            tdo_sy <= 2'h3;
        else
            tdo_sy <= {tdo_sy[0], link.tdo_line};
    end

    // test clock divider and step sequencing
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            busy <= 1'b0;
            step <= 8'h00;
            div <= 8'h00;
            tck_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
        end
        else if (accept)
        begin
            busy <= 1'b1;
            step <= 8'h00;
            div <= 8'h00;
            tms_q <= step_tms(0);
            tdi_q <= 1'b0;
        end
        else if (busy)
        begin
            div <= half ? 8'h00 : div + 8'h01;
            if (half && !tck_q)
                tck_q <= 1'b1;
            else if (half)
            begin
                tck_q <= 1'b0;
                if (last_fall)
                    busy <= 1'b0;
                else
                begin
                    step <= step + 8'h01;
                    tms_q <= step_tms(int'(step) + 1);
                    if (is_ir(int'(step) + 1))
                        tdi_q <= ir_tx[0];
                    else if (is_dr(int'(step) + 1))
                        tdi_q <= dr_tx[0];
                    else
                        tdi_q <= 1'b0;
                end
            end
        end
    end

    // outgoing and captured shift data
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            ir_tx <= '0;
            dr_tx <= '0;
            ir_cap <= '0;
            dr_cap <= '0;
        end
        else if (accept)
        begin
            ir_tx <= req_ir;
            dr_tx <= req_dr;
        end
        else if (half && tck_q)
        begin
            if (is_ir(int'(step) + 1))
                ir_tx <= ir_tx >> 1;
            if (is_dr(int'(step) + 1))
                dr_tx <= dr_tx >> 1;
            // device output stands until the coming fall
            if (is_ir(int'(step)))
                ir_cap <= {tdo_sy[1], ir_cap[`JTP_IR_W-1:1]};
            if (is_dr(int'(step)))
                dr_cap <= {tdo_sy[1], dr_cap[DR_W-1:1]};
        end
    end

    // result buffer storage
    always_ff @(posedge ref_clk)
    begin
        if (push)
            mem[wr_ptr] <= {ir_cap, dr_cap};
    end

    // buffer pointers, fill and handshake flops
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            rsp_valid <= 1'b0;
            req_ready <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= next_count;
            rsp_valid <= (next_count != '0);
            // a full buffer stalls the next scan
            req_ready <= !accept && !busy && (next_count < CW'(DEPTH));
        end
    end

    assign rsp_ir = mem[rd_ptr][`JTP_IR_W+DR_W-1:DR_W];
    assign rsp_dr = mem[rd_ptr][DR_W-1:0];
    assign link.tck = tck_q;
    assign link.tms = tms_q;
    assign link.tdi = tdi_q;
endmodule

/* File: sim/jtp_link_assertions.sv */
// Purpose: edge timing and state checks on the scan link
// Assumes: tck is a slow register that ref_clk samples
// Notes: windows count ref_clk cycles since the last tck edge
`timescale 1ns/1ps
module jtp_link_assertions
    import jtp_pkg::*;
#(
    parameter int DR_W = 8
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // link wires
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    // device status
    input wire jtp_state_e tap_state,
    input wire jtp_ir_t ir_active,
    input wire logic [DR_W-1:0] nf_out
);
    logic tck_d; // tck one cycle late
    logic tms_r; // mode select seen at last rise
    logic [3:0] sf; // cycles since fall, saturating
    logic [3:0] sr; // cycles since rise, saturating
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // reference controller step
    function automatic jtp_state_e nxt(input jtp_state_e s, input logic m);
        case (s)
            ST_TLR: nxt = m ? ST_TLR : ST_RTI;
            ST_RTI: nxt = m ? ST_SELDR : ST_RTI;
            ST_SELDR: nxt = m ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: nxt = m ? ST_EX1DR : ST_SHDR;
            ST_SHDR: nxt = m ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: nxt = m ? ST_UPDDR : ST_PAUDR;
            ST_PAUDR: nxt = m ? ST_EX2DR : ST_PAUDR;
            ST_EX2DR: nxt = m ? ST_UPDDR : ST_SHDR;
            ST_UPDDR: nxt = m ? ST_SELDR : ST_RTI;
            ST_SELIR: nxt = m ? ST_TLR : ST_CAPIR;
            ST_CAPIR: nxt = m ? ST_EX1IR : ST_SHIR;
            ST_SHIR: nxt = m ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: nxt = m ? ST_UPDIR : ST_PAUIR;
            ST_PAUIR: nxt = m ? ST_EX2IR : ST_PAUIR;
            ST_EX2IR: nxt = m ? ST_UPDIR : ST_SHIR;
            default: nxt = m ? ST_SELDR : ST_RTI;
        endcase
    endfunction
    // edge age counters and sampled mode select
    always_ff @(posedge ref_clk)
    begin
        tck_d <= nrst ? tck : 1'b0;
        if (!nrst)
            sf <= 4'hf;
        else if (!tck && tck_d)
            sf <= 4'h0;
        else if (sf != 4'hf)
            sf <= sf + 4'h1;
        if (!nrst)
            sr <= 4'hf;
        else if (tck && !tck_d)
            sr <= 4'h0;
        else if (sr != 4'hf)
            sr <= sr + 4'h1;
        if (tck && !tck_d)
            tms_r <= tms;
    end
    chk_tdo_fall_edge: assert property
        (($changed(tdo) || $changed(tdo_oe)) |-> sf inside {[1:5]})
        else $error("tdo moved away from a tck fall");
    chk_state_rise_edge: assert property ($changed(tap_state) |-> sr inside {[0:4]})
        else $error("state moved away from a tck rise");
    chk_next_state: assert property
        ($changed(tap_state) |-> tap_state == nxt($past(tap_state), tms_r))
        else $error("wrong controller step");
    chk_oe_shift_only: assert property
        (tdo_oe |-> tap_state inside {ST_SHIR, ST_SHDR, ST_EX1IR, ST_EX1DR})
        else $error("tdo driven outside shift");
    chk_oe_rise_shift: assert property
        ($rose(tdo_oe) |-> tap_state inside {ST_SHIR, ST_SHDR})
        else $error("tdo enabled outside shift");
    chk_oe_fall_exit: assert property
        ($fell(tdo_oe) |-> tap_state inside {ST_EX1IR, ST_EX1DR})
        else $error("tdo released outside exit1");
    chk_ir_first_bit: assert property ($rose(tdo_oe) && tap_state == ST_SHIR |-> tdo)
        else $error("first ir bit not one");
    chk_bypass_zero: assert property
        ($rose(tdo_oe) && tap_state == ST_SHDR && ir_active == 8'hff |-> !tdo)
        else $error("bypass first bit not zero");
    chk_ir_update_at: assert property
        ($changed(ir_active) |-> tap_state inside {ST_UPDIR, ST_TLR} && sf inside {[1:5]})
        else $error("instruction changed at wrong time");
    chk_dr_update_at: assert property
        ($changed(nf_out) |-> tap_state == ST_UPDDR && ir_active != 8'hff
            && sf inside {[1:5]})
        else $error("parallel output changed at wrong time");
    chk_host_change_low: assert property (($changed(tms) || $changed(tdi)) |-> !tck)
        else $error("host changed tms or tdi with tck high");
    // main scenarios seen
    cov_ir_update: cover property (tap_state == ST_UPDIR);
    cov_bypass_shift: cover property (tap_state == ST_SHDR && ir_active == 8'hff);
    cov_dr_update: cover property ($changed(nf_out));
endmodule

/* File: sim/jtp_tap_scan_timing_test.sv */
// Purpose: both scan ends joined and driven from the request side
// Assumes: one scan per request, results in request order
// Notes: driver queues expectations, monitor pops them
`timescale 1ns/1ps
module jtp_tap_scan_timing_test
    import jtp_pkg::*;
;
    logic ref_clk = 1'b0; // 40 MHz
    logic nrst = 1'b0; // sync reset
    logic req_valid = 1'b0;
    logic req_ready;
    jtp_ir_t req_ir = 8'h00;
    logic [7:0] req_dr = 8'h00;
    logic rsp_valid;
    logic rsp_ready = 1'b0;
    jtp_ir_t rsp_ir;
    logic [7:0] rsp_dr;
    logic [7:0] nf_in = 8'h00;
    logic [7:0] nf_out;
    jtp_ir_t ir_active;
    jtp_state_e tap_state;
    jtp_state_e prev_st; // state at last check
    jtp_ir_t cur_ir = 8'h00; // instruction of scan in flight
    logic [7:0] last_nf = 8'h00; // expected parallel output
    logic hold = 1'b0; // stalls result side
    logic [15:0] exp_q[$]; // expected {ir, dr}
    jtp_ir_t tab[4] = '{8'h7f, 8'hfe, 8'h00, 8'hff};
    int bad_count = 0;
    int comparisons = 0;
    jtp_link_if link();
    always #12.5 ref_clk = ~ref_clk;
    jtp_dev #(.DR_W(8)) jtp_dev_inst (.ref_clk(ref_clk), .nrst(nrst), .link(link),
        .nf_in(nf_in), .nf_out(nf_out), .ir_active(ir_active), .tap_state(tap_state));
    jtp_host #(.DR_W(8), .TCK_HALF(4), .DEPTH(2)) jtp_host_inst (.ref_clk(ref_clk),
        .nrst(nrst), .link(link), .req_valid(req_valid), .req_ready(req_ready),
        .req_ir(req_ir), .req_dr(req_dr), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_ir(rsp_ir), .rsp_dr(rsp_dr));
    jtp_link_assertions #(.DR_W(8)) jtp_link_assertions_inst (.ref_clk(ref_clk),
        .nrst(nrst), .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo),
        .tdo_oe(link.tdo_oe), .tap_state(tap_state), .ir_active(ir_active),
        .nf_out(nf_out));
    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one request once the host is idle; nf_in only moves between scans
    task automatic send(input jtp_ir_t ir, input logic [7:0] dr);
        logic [7:0] nf;
        int n;
        nf = 8'($urandom);
        n = 0;
        @(negedge ref_clk);
        while (req_ready !== 1'b1 && n < 3000)
        begin
            n++;
            @(negedge ref_clk);
        end
        nf_in = nf;
        req_ir = ir;
        req_dr = dr;
        req_valid = 1'b1;
        cur_ir = ir;
        exp_q.push_back({8'h81, (ir == 8'hff) ? {dr[6:0], 1'b0} : nf});
        if (ir != 8'hff)
            last_nf = dr;
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask
    // result side: random stall, pop and compare; active ir at shift-dr
    always @(negedge ref_clk)
    begin
        rsp_ready = hold ? 1'b0 : 1'($urandom);
        if (rsp_valid === 1'b1 && rsp_ready)
        begin
            if (exp_q.size() == 0)
                chk(16'h0, 16'hffff, "unexpected result");
            else
                chk({rsp_ir, rsp_dr}, exp_q.pop_front(), "result");
        end
        if (tap_state === ST_SHDR && prev_st !== ST_SHDR)
            chk(16'(ir_active), 16'(cur_ir), "active ir");
        prev_st = tap_state;
    end
    // main sequence
    initial
    begin
        int n;
        void'($urandom(32'h70c0ac50));
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        send(8'hff, 8'h05);
        foreach (tab[i])
            send(tab[i], 8'($urandom));
        repeat (6)
            send(8'($urandom), 8'($urandom));
        // stall results until the buffer refuses
        hold = 1'b1;
        send(8'h3c, 8'ha5);
        repeat (400) @(negedge ref_clk);
        // a request offered to a full buffer must not start a scan
        req_valid = 1'b1;
        repeat (60) @(negedge ref_clk);
        chk({14'h0, req_ready, rsp_valid}, 16'h1, "full buffer");
        chk(16'(tap_state), 16'(ST_TLR), "no scan while full");
        req_valid = 1'b0;
        hold = 1'b0;
        send(8'hff, 8'h5a);
        n = 0;
        while (exp_q.size() > 0 && n < 3000)
        begin
            n++;
            @(negedge ref_clk);
        end
        repeat (20) @(negedge ref_clk);
        chk(16'(exp_q.size()), 16'h0, "results left");
        chk(16'(nf_out), 16'(last_nf), "parallel out");
        chk(16'(ir_active), 16'hff, "ir after scan");
        chk(tap_state, ST_TLR, "final state");
        conclude();
    end
    // hang guard
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        conclude();
    end
endmodule
